// ==== src/rtn_network.sv ====
// Behaviour
// - Exchange and quotient transfers copy every bit in place
// - Address upper six bits load exchange
// - Program counter fills address upper six
// - Exchange fills countdown low; top bit separate
// - Exchange fills address low; top bit separate
// - Countdown preset forces octal five
// - Distributor presets force octal 7, 13, 16
// - Address counter only increments or loads
// - Program counter counts upward only
// - Exchange magnitude view omits sign bit
// - Quotient holds six; magnitude omits sign
// - Zero, overflow, sign are single flip-flops
// - Every register except decode has manual clear and set
// - Jump and load groups are decode ORs
// - Countdown decrements; distributor four-bit incrementing
// - Instruction register six bits, bit zero source
// - Master clear resets every flip-flop except the APB answer and its own synchroniser
module rtn_network
    import rtn_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic master_clear_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic jump_group_o,
    output logic load_group_o,
    output logic load_neg_or_subtract_group_o,
    output rtn_flags_t flags_o
);

    logic mclr_meta;
    logic mclr_sync;
    logic clear_all;
    logic [RTN_W_ADDR-1:0] addr_cnt;
    logic [RTN_W_WORD-1:0] prog_cnt;
    logic [RTN_W_WORD-1:0] exchange;
    logic [RTN_W_WORD-1:0] quotient;
    logic [RTN_W_CD-1:0] countdown;
    logic [RTN_W_DIST-1:0] distributor;
    logic [RTN_W_WORD-1:0] instr;
    rtn_flags_t flags;
    logic [RTN_DEC_W-1:0] decode;
    logic [RTN_CMD_W-1:0] subcmd;
    logic [RTN_MAN_W-1:0] manual_clear;
    logic [RTN_MAN_W-1:0] manual_set;
    logic [RTN_W_MAG-1:0] exchange_magnitude;
    logic [RTN_W_MAG-1:0] quotient_magnitude;
    logic wr_en;
    logic setup;
    logic [31:0] next_rdata;
    logic next_err;
    logic top_bit;

    assign clear_all = reset_i | mclr_sync;
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign setup = psel_i & ~penable_i;
    assign top_bit = instr[RTN_TOP_INSTR_BIT];
    assign exchange_magnitude = exchange[RTN_W_WORD-1:1];
    assign quotient_magnitude = quotient[RTN_W_WORD-1:1];

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mclr_meta <= 1'b0;
            mclr_sync <= 1'b0;
        end else begin
            mclr_meta <= master_clear_i;
            mclr_sync <= mclr_meta;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            subcmd <= '0;
            manual_clear <= '0;
            manual_set <= '0;
        end else begin
            subcmd <= '0;
            manual_clear <= '0;
            manual_set <= '0;
            if (wr_en && paddr_i == RTN_OFF_CMD) begin
                subcmd <= pwdata_i[RTN_CMD_W-1:0];
            end else if (wr_en && paddr_i == RTN_OFF_MCLR) begin
                manual_clear <= pwdata_i[RTN_MAN_W-1:0];
            end else if (wr_en && paddr_i == RTN_OFF_MSET) begin
                manual_set <= pwdata_i[RTN_MAN_W-1:0];
            end
        end
    end

    // Memory address counter
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            addr_cnt <= '0;
        end else if (manual_clear[RTN_T_ADDR]) begin
            addr_cnt <= '0;
        end else if (manual_set[RTN_T_ADDR]) begin
            addr_cnt <= '1;
        end else if (wr_en && paddr_i == RTN_OFF_ADDR) begin
            addr_cnt <= pwdata_i[RTN_W_ADDR-1:0];
        end else if (subcmd[RTN_C_PROG_TO_ADDR]) begin
            addr_cnt <= {prog_cnt, addr_cnt[0]};
        end else if (subcmd[RTN_C_EXCH_TO_ADDR]) begin
            addr_cnt <= {top_bit, exchange};
        end else if (subcmd[RTN_C_TOP_TO_ADDR]) begin
            addr_cnt <= {top_bit, addr_cnt[RTN_W_ADDR-2:0]};
        end else if (subcmd[RTN_C_INC_ADDR]) begin
            addr_cnt <= addr_cnt + 7'h01;
        end
    end

    // Program address counter
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            prog_cnt <= '0;
        end else if (manual_clear[RTN_T_PROG]) begin
            prog_cnt <= '0;
        end else if (manual_set[RTN_T_PROG]) begin
            prog_cnt <= '1;
        end else if (wr_en && paddr_i == RTN_OFF_PROG) begin
            prog_cnt <= pwdata_i[RTN_W_WORD-1:0];
        end else if (subcmd[RTN_C_INC_PROG]) begin
            prog_cnt <= prog_cnt + 6'h01;
        end
    end

    // Exchange register
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            exchange <= '0;
        end else if (manual_clear[RTN_T_EXCH]) begin
            exchange <= '0;
        end else if (manual_set[RTN_T_EXCH]) begin
            exchange <= '1;
        end else if (wr_en && paddr_i == RTN_OFF_EXCH) begin
            exchange <= pwdata_i[RTN_W_WORD-1:0];
        end else if (subcmd[RTN_C_ADDR_TO_EXCH]) begin
            exchange <= addr_cnt[RTN_W_ADDR-1:1];
        end else if (subcmd[RTN_C_QUOT_TO_EXCH]) begin
            exchange <= quotient;
        end
    end

    // Quotient register
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            quotient <= '0;
        end else if (manual_clear[RTN_T_QUOT]) begin
            quotient <= '0;
        end else if (manual_set[RTN_T_QUOT]) begin
            quotient <= '1;
        end else if (wr_en && paddr_i == RTN_OFF_QUOT) begin
            quotient <= pwdata_i[RTN_W_WORD-1:0];
        end else if (subcmd[RTN_C_EXCH_TO_QUOT]) begin
            quotient <= exchange;
        end
    end

    // Count-down counter
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            countdown <= '0;
        end else if (manual_clear[RTN_T_CD]) begin
            countdown <= '0;
        end else if (manual_set[RTN_T_CD]) begin
            countdown <= '1;
        end else if (wr_en && paddr_i == RTN_OFF_CD) begin
            countdown <= pwdata_i[RTN_W_CD-1:0];
        end else if (subcmd[RTN_C_PRESET_CD5]) begin
            countdown <= RTN_CD_PRESET;
        end else if (subcmd[RTN_C_EXCH_TO_CD]) begin
            countdown <= {top_bit, exchange};
        end else if (subcmd[RTN_C_TOP_TO_CD]) begin
            countdown <= {top_bit, countdown[RTN_W_CD-2:0]};
        end else if (subcmd[RTN_C_DEC_CD]) begin
            countdown <= countdown - 7'h01;
        end
    end

    // Distributor counter
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            distributor <= '0;
        end else if (manual_clear[RTN_T_DIST]) begin
            distributor <= '0;
        end else if (manual_set[RTN_T_DIST]) begin
            distributor <= '1;
        end else if (wr_en && paddr_i == RTN_OFF_DIST) begin
            distributor <= pwdata_i[RTN_W_DIST-1:0];
        end else if (subcmd[RTN_C_PRESET_D7]) begin
            distributor <= RTN_D_PRESET_A;
        end else if (subcmd[RTN_C_PRESET_D13]) begin
            distributor <= RTN_D_PRESET_B;
        end else if (subcmd[RTN_C_PRESET_D16]) begin
            distributor <= RTN_D_PRESET_C;
        end else if (subcmd[RTN_C_INC_DIST]) begin
            distributor <= distributor + 4'h1;
        end
    end

    // Instruction register and decode inputs
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            instr <= '0;
            decode <= '0;
        end else begin
            if (manual_clear[RTN_T_INSTR]) begin
                instr <= '0;
            end else if (manual_set[RTN_T_INSTR]) begin
                instr <= '1;
            end else if (wr_en && paddr_i == RTN_OFF_INSTR) begin
                instr <= pwdata_i[RTN_W_WORD-1:0];
            end
            if (wr_en && paddr_i == RTN_OFF_DECODE) begin
                decode <= pwdata_i[RTN_DEC_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            flags <= RTN_FLAGS_RESET;
        end else begin
            if (manual_clear[RTN_T_ZERO]) begin
                flags.logic_zero_ff <= 1'b0;
            end else if (manual_set[RTN_T_ZERO]) begin
                flags.logic_zero_ff <= 1'b1;
            end else if (wr_en && paddr_i == RTN_OFF_FLAGS) begin
                flags.logic_zero_ff <= pwdata_i[RTN_F_ZERO];
            end
            if (manual_clear[RTN_T_OVF]) begin
                flags.overflow_ff <= 1'b0;
            end else if (manual_set[RTN_T_OVF]) begin
                flags.overflow_ff <= 1'b1;
            end else if (wr_en && paddr_i == RTN_OFF_FLAGS) begin
                flags.overflow_ff <= pwdata_i[RTN_F_OVF];
            end
            if (manual_clear[RTN_T_SIGN]) begin
                flags.sign <= 1'b0;
            end else if (manual_set[RTN_T_SIGN]) begin
                flags.sign <= 1'b1;
            end else if (wr_en && paddr_i == RTN_OFF_FLAGS) begin
                flags.sign <= pwdata_i[RTN_F_SIGN];
            end
        end
    end

    // Group outputs and flags
    always_ff @(posedge clk_sys_i) begin
        if (clear_all) begin
            jump_group_o <= 1'b0;
            load_group_o <= 1'b0;
            load_neg_or_subtract_group_o <= 1'b0;
            flags_o <= RTN_FLAGS_RESET;
        end else begin
            jump_group_o <= decode[RTN_D_JSUB] | decode[RTN_D_JUNC]
                | decode[RTN_D_JSIGN] | decode[RTN_D_JZERO];
            load_group_o <= decode[RTN_D_LDPOS] | decode[RTN_D_LDNEG];
            load_neg_or_subtract_group_o <= decode[RTN_D_LDNEG]
                | decode[RTN_D_MINUS];
            flags_o <= flags;
        end
    end

    // Read decode
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (paddr_i == RTN_OFF_CMD || paddr_i == RTN_OFF_MCLR
            || paddr_i == RTN_OFF_MSET) begin
            next_rdata = 32'h0000_0000;
        end else if (paddr_i == RTN_OFF_DECODE) begin
            next_rdata = {25'h0, decode};
        end else if (paddr_i == RTN_OFF_ADDR) begin
            next_rdata = {25'h0, addr_cnt};
        end else if (paddr_i == RTN_OFF_PROG) begin
            next_rdata = {26'h0, prog_cnt};
        end else if (paddr_i == RTN_OFF_EXCH) begin
            next_rdata = {26'h0, exchange};
        end else if (paddr_i == RTN_OFF_QUOT) begin
            next_rdata = {26'h0, quotient};
        end else if (paddr_i == RTN_OFF_CD) begin
            next_rdata = {25'h0, countdown};
        end else if (paddr_i == RTN_OFF_DIST) begin
            next_rdata = {28'h0, distributor};
        end else if (paddr_i == RTN_OFF_INSTR) begin
            next_rdata = {26'h0, instr};
        end else if (paddr_i == RTN_OFF_FLAGS) begin
            next_rdata = {29'h0, flags};
        end else if (paddr_i == RTN_OFF_XMAG) begin
            next_rdata = {27'h0, exchange_magnitude};
        end else if (paddr_i == RTN_OFF_QMAG) begin
            next_rdata = {27'h0, quotient_magnitude};
        end else if (paddr_i == RTN_OFF_GROUPS) begin
            next_rdata = {29'h0, load_neg_or_subtract_group_o,
                load_group_o, jump_group_o};
        end else begin
            next_err = 1'b1;
        end
    end

    // APB answer, latched in setup phase
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            pready_o <= 1'b0;
        end else begin
            pready_o <= 1'b1;
            if (setup) begin
                prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
                pslverr_o <= next_err;
            end
        end
    end

endmodule

// ==== src/rtn_pkg.sv ====
package rtn_pkg;

    // Register widths
    localparam int RTN_W_ADDR = 7;
    localparam int RTN_W_WORD = 6;
    localparam int RTN_W_MAG = 5;
    localparam int RTN_W_CD = 7;
    localparam int RTN_W_DIST = 4;

    // Byte offsets
    localparam logic [11:0] RTN_OFF_CMD = 12'h000;
    localparam logic [11:0] RTN_OFF_MCLR = 12'h004;
    localparam logic [11:0] RTN_OFF_MSET = 12'h008;
    localparam logic [11:0] RTN_OFF_DECODE = 12'h00c;
    localparam logic [11:0] RTN_OFF_ADDR = 12'h010;
    localparam logic [11:0] RTN_OFF_PROG = 12'h014;
    localparam logic [11:0] RTN_OFF_EXCH = 12'h018;
    localparam logic [11:0] RTN_OFF_QUOT = 12'h01c;
    localparam logic [11:0] RTN_OFF_CD = 12'h020;
    localparam logic [11:0] RTN_OFF_DIST = 12'h024;
    localparam logic [11:0] RTN_OFF_INSTR = 12'h028;
    localparam logic [11:0] RTN_OFF_FLAGS = 12'h02c;
    localparam logic [11:0] RTN_OFF_XMAG = 12'h030;
    localparam logic [11:0] RTN_OFF_QMAG = 12'h034;
    localparam logic [11:0] RTN_OFF_GROUPS = 12'h038;

    // Subcommand bits in the command register
    localparam int RTN_CMD_W = 16;
    localparam int RTN_C_ADDR_TO_EXCH = 0;
    localparam int RTN_C_PROG_TO_ADDR = 1;
    localparam int RTN_C_EXCH_TO_CD = 2;
    localparam int RTN_C_EXCH_TO_ADDR = 3;
    localparam int RTN_C_TOP_TO_CD = 4;
    localparam int RTN_C_TOP_TO_ADDR = 5;
    localparam int RTN_C_PRESET_CD5 = 6;
    localparam int RTN_C_PRESET_D7 = 7;
    localparam int RTN_C_PRESET_D13 = 8;
    localparam int RTN_C_PRESET_D16 = 9;
    localparam int RTN_C_INC_ADDR = 10;
    localparam int RTN_C_INC_PROG = 11;
    localparam int RTN_C_DEC_CD = 12;
    localparam int RTN_C_INC_DIST = 13;
    localparam int RTN_C_EXCH_TO_QUOT = 14;
    localparam int RTN_C_QUOT_TO_EXCH = 15;

    // Manual clear and set target bits
    localparam int RTN_MAN_W = 10;
    localparam int RTN_T_ADDR = 0;
    localparam int RTN_T_PROG = 1;
    localparam int RTN_T_EXCH = 2;
    localparam int RTN_T_QUOT = 3;
    localparam int RTN_T_CD = 4;
    localparam int RTN_T_DIST = 5;
    localparam int RTN_T_INSTR = 6;
    localparam int RTN_T_ZERO = 7;
    localparam int RTN_T_OVF = 8;
    localparam int RTN_T_SIGN = 9;

    // Instruction decode bits
    localparam int RTN_DEC_W = 7;
    localparam int RTN_D_JSUB = 0;
    localparam int RTN_D_JUNC = 1;
    localparam int RTN_D_JSIGN = 2;
    localparam int RTN_D_JZERO = 3;
    localparam int RTN_D_LDPOS = 4;
    localparam int RTN_D_LDNEG = 5;
    localparam int RTN_D_MINUS = 6;

    // Preset values: octal 5, 7, 13, 16
    localparam logic [6:0] RTN_CD_PRESET = 7'h05;
    localparam logic [3:0] RTN_D_PRESET_A = 4'h7;
    localparam logic [3:0] RTN_D_PRESET_B = 4'hb;
    localparam logic [3:0] RTN_D_PRESET_C = 4'he;

    // Field positions
    localparam int RTN_TOP_INSTR_BIT = 0;
    localparam int RTN_SIGN_BIT = 0;
    localparam int RTN_F_ZERO = 0;
    localparam int RTN_F_OVF = 1;
    localparam int RTN_F_SIGN = 2;

    typedef struct packed {
        logic sign;
        logic overflow_ff;
        logic logic_zero_ff;
    } rtn_flags_t;

    localparam rtn_flags_t RTN_FLAGS_RESET = '{1'b0, 1'b0, 1'b0};

endpackage

// ==== tb/rtn_network_monitor.sv ====
module rtn_network_monitor
    import rtn_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic master_clear_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic jump_group_o,
    input wire logic load_group_o,
    input wire logic load_neg_or_subtract_group_o,
    input wire rtn_flags_t flags_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    sequence wr_at(logic [11:0] a);
        psel_i && penable_i && pwrite_i && paddr_i == a;
    endsequence
    sequence setup_at(logic [11:0] a);
        psel_i && !penable_i && paddr_i == a;
    endsequence

    a_jump_group_or: assert property (wr_at(RTN_OFF_DECODE) ##1 1'b1 |=>
        jump_group_o == (|$past(pwdata_i[3:0], 2)))
        else $error("jump group wrong");
    a_load_group_or: assert property (wr_at(RTN_OFF_DECODE) ##1 1'b1 |=>
        load_group_o == (|$past(pwdata_i[5:4], 2)))
        else $error("load group wrong");
    a_negsub_group_or: assert property (wr_at(RTN_OFF_DECODE) ##1 1'b1 |=>
        load_neg_or_subtract_group_o == (|$past(pwdata_i[6:5], 2)))
        else $error("negate or subtract group wrong");
    a_flag_bits_follow: assert property (wr_at(RTN_OFF_FLAGS) ##1 1'b1 |=>
        flags_o == $past(pwdata_i[2:0], 2))
        else $error("flags port wrong");
    a_master_clear_all: assert property (master_clear_i [*3] |-> ##[1:5]
        (flags_o == RTN_FLAGS_RESET && !jump_group_o && !load_group_o &&
        !load_neg_or_subtract_group_o))
        else $error("master clear missed");
    a_addr_width_seven: assert property (setup_at(RTN_OFF_ADDR) |=>
        prdata_o[31:7] == '0) else $error("addr width");
    a_prog_width_six: assert property (setup_at(RTN_OFF_PROG) |=>
        prdata_o[31:6] == '0) else $error("prog width");
    a_xmag_width_five: assert property (setup_at(RTN_OFF_XMAG) |=>
        prdata_o[31:5] == '0) else $error("xmag width");
    a_qmag_width_five: assert property (setup_at(RTN_OFF_QMAG) |=>
        prdata_o[31:5] == '0) else $error("qmag width");
    a_dist_width_four: assert property (setup_at(RTN_OFF_DIST) |=>
        prdata_o[31:4] == '0) else $error("dist width");
endmodule

bind rtn_network rtn_network_monitor u_mon (.clk_sys_i, .reset_i,
    .master_clear_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .jump_group_o, .load_group_o,
    .load_neg_or_subtract_group_o, .flags_o);

// ==== tb/rtn_network_tb_top.sv ====
`define CHK(nm, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
end

module rtn_network_tb_top
    import rtn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i, reset_i, master_clear_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd_data;
    logic pready_o, pslverr_o, jump_group_o, load_group_o, rd_err;
    logic load_neg_or_subtract_group_o;
    rtn_flags_t flags_o;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    rtn_network DUT (.clk_sys_i, .reset_i, .master_clear_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .jump_group_o, .load_group_o,
        .load_neg_or_subtract_group_o, .flags_o);

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1);
        rd_data = prdata_o;
        rd_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic cmd(input int b);
        wr(RTN_OFF_CMD, 32'h1 << b);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd_data)
    endtask

    task automatic t_zero(input string nm);
        for (int a = 'h10; a <= 'h38; a += 4)
            rd_chk(12'(a), 32'h0);
        $display("test %s done", nm);
    endtask

    task automatic t_xfer();
        wr(RTN_OFF_ADDR, 32'h5b);
        cmd(RTN_C_ADDR_TO_EXCH);
        rd_chk(RTN_OFF_EXCH, 32'h2d);
        wr(RTN_OFF_PROG, 32'h35);
        cmd(RTN_C_PROG_TO_ADDR);
        rd_chk(RTN_OFF_ADDR, 32'h6b);
        wr(RTN_OFF_INSTR, 32'h01);
        wr(RTN_OFF_EXCH, 32'h2a);
        cmd(RTN_C_EXCH_TO_CD);
        rd_chk(RTN_OFF_CD, 32'h6a);
        cmd(RTN_C_EXCH_TO_ADDR);
        rd_chk(RTN_OFF_ADDR, 32'h6a);
        wr(RTN_OFF_INSTR, 32'h3e);
        cmd(RTN_C_TOP_TO_CD);
        rd_chk(RTN_OFF_CD, 32'h2a);
        cmd(RTN_C_TOP_TO_ADDR);
        rd_chk(RTN_OFF_ADDR, 32'h2a);
        cmd(RTN_C_EXCH_TO_QUOT);
        rd_chk(RTN_OFF_QUOT, 32'h2a);
        wr(RTN_OFF_QUOT, 32'h13);
        cmd(RTN_C_QUOT_TO_EXCH);
        rd_chk(RTN_OFF_EXCH, 32'h13);
        rd_chk(RTN_OFF_XMAG, 32'h09);
        wr(RTN_OFF_QUOT, 32'h2b);
        rd_chk(RTN_OFF_QMAG, 32'h15);
        $display("test transfers done");
    endtask

    task automatic t_count();
        logic [11:0] of[12] = '{RTN_OFF_ADDR, RTN_OFF_ADDR, RTN_OFF_PROG,
            RTN_OFF_PROG, RTN_OFF_CD, RTN_OFF_CD, RTN_OFF_DIST, RTN_OFF_DIST,
            RTN_OFF_CD, RTN_OFF_DIST, RTN_OFF_DIST, RTN_OFF_DIST};
        logic [6:0] st[12] = '{7'h3f, 7'h7f, 7'h1f, 7'h3f, 7'h40, 7'h00,
            7'h07, 7'h0f, 7'h7f, 7'h00, 7'h00, 7'h0f};
        logic [6:0] ex[12] = '{7'h40, 7'h00, 7'h20, 7'h00, 7'h3f, 7'h7f,
            7'h08, 7'h00, 7'h05, 7'h07, 7'h0b, 7'h0e};
        int bt[12] = '{RTN_C_INC_ADDR, RTN_C_INC_ADDR, RTN_C_INC_PROG,
            RTN_C_INC_PROG, RTN_C_DEC_CD, RTN_C_DEC_CD, RTN_C_INC_DIST,
            RTN_C_INC_DIST, RTN_C_PRESET_CD5, RTN_C_PRESET_D7,
            RTN_C_PRESET_D13, RTN_C_PRESET_D16};
        for (int i = 0; i < 12; i++) begin
            wr(of[i], 32'(st[i]));
            cmd(bt[i]);
            rd_chk(of[i], 32'(ex[i]));
        end
        $display("test counters done");
    endtask

    task automatic t_manual();
        logic [6:0] ones[8] = '{7'h7f, 7'h3f, 7'h3f, 7'h3f, 7'h7f, 7'h0f,
            7'h3f, 7'h07};
        wr(RTN_OFF_FLAGS, 32'h5);
        `CHK("flags port", 3'b101, flags_o)
        wr(RTN_OFF_MSET, 32'h3ff);
        for (int i = 0; i < 8; i++)
            rd_chk(12'(RTN_OFF_ADDR + 4 * i), 32'(ones[i]));
        `CHK("flags port", 3'b111, flags_o)
        wr(RTN_OFF_MCLR, 32'h002);
        rd_chk(RTN_OFF_PROG, 32'h0);
        rd_chk(RTN_OFF_ADDR, 32'h7f);
        wr(RTN_OFF_MCLR, 32'h3fd);
        for (int i = 0; i < 8; i++)
            rd_chk(12'(RTN_OFF_ADDR + 4 * i), 32'h0);
        $display("test manual done");
    endtask

    task automatic t_groups();
        logic [2:0] e;
        for (int i = 0; i < 7; i++) begin
            wr(RTN_OFF_DECODE, 32'h1 << i);
            e = {i inside {[5:6]}, i inside {[4:5]}, i < 4};
            `CHK("jump", e[0], jump_group_o)
            `CHK("load", e[1], load_group_o)
            `CHK("negsub", e[2], load_neg_or_subtract_group_o)
            rd_chk(RTN_OFF_GROUPS, 32'(e));
        end
        $display("test groups done");
    endtask

    task automatic t_mclr();
        wr(RTN_OFF_MSET, 32'h3ff);
        master_clear_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        master_clear_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        `CHK("flags port", 3'b000, flags_o)
        t_zero("master clear");
        wr(RTN_OFF_XMAG, 32'h1f);
        rd_chk(RTN_OFF_XMAG, 32'h0);
        apb(12'h03c, 1'b0, 32'h0);
        `CHK("unmapped", 1'b1, rd_err)
        apb(RTN_OFF_ADDR, 1'b0, 32'h0);
        `CHK("mapped", 1'b0, rd_err)
        $display("test unmapped done");
    endtask

    initial begin
        reset_i = 1'b1;
        master_clear_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        repeat (16) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        t_zero("reset");
        t_xfer();
        t_count();
        t_manual();
        t_groups();
        t_mclr();
        conclude();
    end
endmodule
